/* tsi_pkg.sv */
package tsi_pkg;

    // Timing
    localparam int CLK_NS = 25;
    localparam int CLK_MHZ = 40;
    localparam int T_TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYC_DFLT = T_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TO_W = 24;
    localparam int T_SCL_NS = 2500;
    localparam int QTR_CYC = (T_SCL_NS / 4) / CLK_NS;
    localparam int QC_W = 6;
    localparam logic [1:0] FILT_FS = 2'h3;
    localparam logic [1:0] FILT_HS = 2'h1;

    // Bus codes
    localparam logic [6:0] ADDR_BASE = 7'h44;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [4:0] HS_PREFIX = 5'h01;
    localparam logic [7:0] HS_CODE = 8'h08;
    localparam logic [7:0] PTR_TEMP = 8'h00;

    // Controller register map
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_WDATA = 12'h008;
    localparam logic [11:0] OFF_RDATA = 12'h00C;
    localparam logic [11:0] OFF_STAT = 12'h010;
    localparam int CMD_RD_BIT = 8;
    localparam int CMD_DATA_BIT = 9;
    localparam int CMD_HS_BIT = 10;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;

    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_RX = 3'h1,
        DS_ACK = 3'h2,
        DS_TX = 3'h3,
        DS_RACK = 3'h4
    } tsi_dev_st_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'h0,
        MS_START = 2'h1,
        MS_BIT = 2'h2,
        MS_STOP = 2'h3
    } tsi_mst_st_t;

    typedef struct packed {
        logic scl_s1; logic scl_s2; logic sda_s1; logic sda_s2;
        logic [2:0] strap_s1; logic [2:0] strap_s2; logic [1:0] strap_cnt;
        logic [1:0] scl_c; logic [1:0] sda_c; logic scl_f; logic sda_f;
        tsi_dev_st_t st; logic [3:0] bit_cnt; logic [7:0] sh;
        logic [1:0] bidx; logic rw; logic gc; logic ack;
        logic [7:0] ptr; logic [7:0] wd_hi; logic [15:0] word;
        logic sda_low; logic hs; logic [TO_W-1:0] to_cnt;
        logic we; logic [15:0] wdata; logic flag; logic alert;
        logic [6:0] addr;
    } tsi_dev_state_t;

    localparam tsi_dev_state_t DEV_RST = '{scl_s1: 1'b1, scl_s2: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, scl_f: 1'b1, sda_f: 1'b1, st: DS_IDLE,
        ptr: PTR_TEMP, flag: 1'b1, alert: 1'b1, addr: ADDR_BASE,
        default: '0};

    typedef struct packed {
        logic sda_s1; logic sda_s2; tsi_mst_st_t st;
        logic [QC_W-1:0] qc; logic [1:0] ph; logic [3:0] bit_cnt;
        logic [7:0] sh; logic [2:0] seq; logic rd; logic wdat; logic hs;
        logic [7:0] ptr; logic [6:0] addr; logic [15:0] wdata;
        logic [15:0] rdata; logic nack; logic rack;
        logic scl_low; logic sda_low;
        logic pready; logic pslverr; logic [31:0] prdata;
    } tsi_mst_state_t;

    localparam tsi_mst_state_t MST_RST = '{sda_s1: 1'b1, sda_s2: 1'b1,
        st: MS_IDLE, addr: ADDR_BASE, default: '0};

endpackage : tsi_pkg

/* tsi_bus_if.sv */
`timescale 1ns/10ps
interface tsi_bus_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl;
    logic sda;

    // Wired-AND with pull-ups: a released pin reads high
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
    modport mst (input scl, input sda, output m_scl_o, output m_scl_oe_n,
        output m_sda_o, output m_sda_oe_n);
endinterface : tsi_bus_if

/* tsi_dev.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - Write: address, pointer byte, then data
// - Reads source register chosen by pointer
// - Pointer holds between transfers
// - Words move high byte first
// - Slave only, SCL never driven
// - Receiver acks address, pointer, each byte but general-call data
// - Transmitter sends high byte, then low
// - NACK, START or STOP ends read
// - Alert pin active only in interrupt mode
// - Warning flag level follows polarity bit
// - High-speed code unacked, filters shortened
// - High-speed persists until STOP
// - General call: ack two bytes, discard
// - Zero read address sends pointed word
// - SCL low timeout releases SDA, idles
// - Master keeps SCL above minimum rate
// - START and STOP detected, end transfers
// - Master sets byte count, unlimited
// - Ack holds SDA low through clock
// - Address strapped among eight values
// - Bits shift most significant first
module tsi_dev
    import tsi_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYC_DFLT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Two-wire bus
    tsi_bus_if.dev bus,
    // Address straps
    input wire logic [1:0] address_strap_a,
    input wire logic address_strap_b,
    // Register file side
    output logic [7:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    output logic [15:0] reg_wdata,
    output logic reg_we,
    // Warning logic and high-speed status
    input wire logic [15:0] temp_value,
    input wire logic [15:0] upper_temp_limit,
    input wire logic [15:0] lower_temp_limit,
    input wire logic interrupt_mode_select,
    input wire logic warning_polarity,
    output logic warning_condition_flag,
    output logic alert_o,
    output logic hs_mode
);

    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);

    tsi_dev_state_t q;
    tsi_dev_state_t d;
    logic [1:0] lim;
    logic nscl;
    logic nsda;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    function automatic logic [2:0] filt(input logic s, input logic f,
            input logic [1:0] c, input logic [1:0] lm);
        if (s == f) begin
            filt = {f, 2'h0};
        end else if (c == lm) begin
            filt = {s, 2'h0};
        end else begin
            filt = {f, c + 2'h1};
        end
    endfunction : filt

    always_comb begin
        d = q;
        d.we = 1'b0;
        d.scl_s1 = bus.scl;
        d.scl_s2 = q.scl_s1;
        d.sda_s1 = bus.sda;
        d.sda_s2 = q.sda_s1;
        d.strap_s1 = {address_strap_b, address_strap_a};
        d.strap_s2 = q.strap_s1;
        // Shorter glitch filter once in high-speed mode
        lim = q.hs ? FILT_HS : FILT_FS;
        {nscl, d.scl_c} = filt(q.scl_s2, q.scl_f, q.scl_c, lim);
        {nsda, d.sda_c} = filt(q.sda_s2, q.sda_f, q.sda_c, lim);
        d.scl_f = nscl;
        d.sda_f = nsda;
        rise = nscl & ~q.scl_f;
        fall = ~nscl & q.scl_f;
        start = q.scl_f & nscl & q.sda_f & ~nsda;
        stop = q.scl_f & nscl & ~q.sda_f & nsda;

        // Straps caught once the synchroniser has filled
        if (q.strap_cnt != 2'h3) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
            if (q.strap_cnt == 2'h2) begin
                d.addr = ADDR_BASE + {4'h0, q.strap_s2};
            end
        end

        if ($signed(temp_value) >= $signed(upper_temp_limit)) begin
            d.flag = warning_polarity;
        end else if ($signed(temp_value) <= $signed(lower_temp_limit)) begin
            d.flag = ~warning_polarity;
        end
        d.alert = interrupt_mode_select ? q.flag : 1'b1;

        if (nscl) begin
            d.to_cnt = '0;
        end else if (q.to_cnt != TO_LAST) begin
            d.to_cnt = q.to_cnt + 1'b1;
        end

        if (stop) begin
            d.st = DS_IDLE;
            d.sda_low = 1'b0;
            d.hs = 1'b0;
        end else if (start) begin
            d.st = DS_RX;
            d.bit_cnt = 4'h0;
            d.bidx = 2'h0;
            d.sda_low = 1'b0;
        end else if (q.to_cnt == TO_LAST) begin
            // Held until SCL rises; only a START rearms the slave
            d.st = DS_IDLE;
            d.sda_low = 1'b0;
        end else begin
            case (q.st)
                DS_IDLE: begin
                    d.sda_low = 1'b0;
                end
                DS_RX: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], nsda};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (fall && q.bit_cnt == 4'h8) begin
                        d.ack = 1'b0;
                        case (q.bidx)
                            2'h0: begin
                                if (q.sh[7:3] == HS_PREFIX) begin
                                    d.hs = 1'b1;
                                end else if (q.sh[7:1] == q.addr) begin
                                    d.ack = 1'b1;
                                    d.rw = q.sh[0];
                                    d.gc = 1'b0;
                                end else if (q.sh[7:1] == GC_ADDR) begin
                                    d.ack = 1'b1;
                                    d.rw = q.sh[0];
                                    d.gc = ~q.sh[0];
                                end
                                // Any other address stays unanswered
                            end
                            2'h1: begin
                                d.ack = 1'b1;
                                if (!q.gc) begin
                                    d.ptr = q.sh;
                                end
                            end
                            2'h2: begin
                                d.ack = ~q.gc;
                                d.wd_hi = q.sh;
                            end
                            default: begin
                                d.ack = 1'b1;
                                d.we = 1'b1;
                                d.wdata = {q.wd_hi, q.sh};
                            end
                        endcase
                        d.st = d.ack ? DS_ACK : DS_IDLE;
                        d.sda_low = d.ack;
                    end
                end
                DS_ACK: begin
                    // Low held across the whole ninth clock
                    if (fall) begin
                        d.bit_cnt = 4'h0;
                        if (q.rw) begin
                            d.st = DS_TX;
                            d.word = reg_rdata;
                            d.sh = reg_rdata[15:8];
                            d.sda_low = ~reg_rdata[15];
                            d.bidx = 2'h2;
                        end else begin
                            d.st = DS_RX;
                            d.sda_low = 1'b0;
                            d.bidx = (q.bidx == 2'h3) ? 2'h2 : q.bidx + 2'h1;
                        end
                    end
                end
                DS_TX: begin
                    if (fall) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'h7) begin
                            d.st = DS_RACK;
                            d.sda_low = 1'b0;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_low = ~q.sh[6];
                        end
                    end
                end
                DS_RACK: begin
                    if (rise) begin
                        d.ack = ~nsda;
                        if (nsda) begin
                            d.st = DS_IDLE;
                        end
                    end else if (fall && q.ack) begin
                        d.st = DS_TX;
                        d.bit_cnt = 4'h0;
                        // Low byte after high; then the word again
                        if (q.bidx == 2'h2) begin
                            d.sh = q.word[7:0];
                            d.sda_low = ~q.word[7];
                            d.bidx = 2'h3;
                        end else begin
                            d.sh = q.word[15:8];
                            d.sda_low = ~q.word[15];
                            d.bidx = 2'h2;
                        end
                    end
                end
                default: begin
                    d.st = DS_IDLE;
                    d.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // Only SDA has a driver; SCL is listened to only
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe_n = ~q.sda_low;
    assign reg_addr = q.ptr;
    assign reg_wdata = q.wdata;
    assign reg_we = q.we;
    assign warning_condition_flag = q.flag;
    assign alert_o = q.alert;
    assign hs_mode = q.hs;

endmodule : tsi_dev

/* tsi_mst.sv */
`timescale 1ns/10ps
module tsi_mst
    import tsi_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus
    tsi_bus_if.mst bus
);

    localparam logic [QC_W-1:0] QTR_LAST = QC_W'(QTR_CYC - 1);

    tsi_mst_state_t q;
    tsi_mst_state_t d;
    logic tick;
    logic wr;
    logic [2:0] last;
    logic [2:0] nseq;
    logic [7:0] nb;
    logic ntx;
    logic tx_cur;

    function automatic logic is_tx(input logic [2:0] s, input logic r);
        is_tx = ~(r & (s >= 3'h2));
    endfunction : is_tx

    always_comb begin
        d = q;
        d.sda_s1 = bus.sda;
        d.sda_s2 = q.sda_s1;
        wr = psel & penable & q.pready & pwrite;
        d.pready = psel & ~penable;
        if (psel && !penable) begin
            d.pslverr = 1'b0;
            d.prdata = '0;
            case (paddr)
                OFF_CMD: d.prdata = '0;
                OFF_ADDR: d.prdata = {25'h0, q.addr};
                OFF_WDATA: d.prdata = {16'h0, q.wdata};
                OFF_RDATA: d.prdata = {16'h0, q.rdata};
                OFF_STAT: begin
                    d.prdata[STAT_BUSY_BIT] = (q.st != MS_IDLE);
                    d.prdata[STAT_NACK_BIT] = q.nack;
                end
                default: d.pslverr = 1'b1;
            endcase
        end
        if (wr && paddr == OFF_ADDR) begin
            d.addr = pwdata[6:0];
        end
        if (wr && paddr == OFF_WDATA) begin
            d.wdata = pwdata[15:0];
        end

        last = q.rd ? 3'h3 : (q.wdat ? 3'h4 : 3'h2);
        tick = (q.qc == QTR_LAST);
        d.qc = (q.st == MS_IDLE || tick) ? '0 : q.qc + 1'b1;
        nseq = (q.st == MS_START) ? q.seq : q.seq + 3'h1;
        tx_cur = is_tx(q.seq, q.rd);
        ntx = is_tx(nseq, q.rd);
        case (nseq)
            3'h0: nb = HS_CODE;
            3'h1: nb = {q.addr, q.rd};
            3'h2: nb = q.rd ? 8'hFF : q.ptr;
            3'h3: nb = q.rd ? 8'hFF : q.wdata[15:8];
            default: nb = q.wdata[7:0];
        endcase

        case (q.st)
            MS_IDLE: begin
                // Commands while busy are dropped
                if (wr && paddr == OFF_CMD) begin
                    d.ptr = pwdata[7:0];
                    d.rd = pwdata[CMD_RD_BIT];
                    d.wdat = pwdata[CMD_DATA_BIT];
                    d.hs = pwdata[CMD_HS_BIT];
                    d.seq = pwdata[CMD_HS_BIT] ? 3'h0 : 3'h1;
                    d.nack = 1'b0;
                    d.st = MS_START;
                    d.ph = 2'h0;
                    d.scl_low = 1'b1;
                    d.sda_low = 1'b0;
                end
            end
            MS_START: begin
                if (tick) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.scl_low = 1'b0;
                        2'h1: d.sda_low = 1'b1;
                        2'h2: d.scl_low = 1'b1;
                        default: begin
                            d.st = MS_BIT;
                            d.bit_cnt = 4'h0;
                            d.sh = nb;
                            d.sda_low = ntx & ~nb[7];
                        end
                    endcase
                end
            end
            MS_BIT: begin
                if (tick) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.scl_low = 1'b0;
                        2'h1: begin
                            if (q.bit_cnt == 4'h8) begin
                                d.rack = q.sda_s2;
                            end else begin
                                d.sh = {q.sh[6:0], q.sda_s2};
                            end
                        end
                        2'h2: d.scl_low = 1'b1;
                        default: begin
                            if (q.bit_cnt == 4'h8) begin
                                if (!tx_cur && q.seq == 3'h2) begin
                                    d.rdata[15:8] = q.sh;
                                end
                                if (!tx_cur && q.seq == 3'h3) begin
                                    d.rdata[7:0] = q.sh;
                                end
                                if (q.seq == 3'h0) begin
                                    // Repeated START after the speed code
                                    d.st = MS_START;
                                    d.seq = 3'h1;
                                    d.sda_low = 1'b0;
                                end else if ((tx_cur & q.rack)
                                        || q.seq == last) begin
                                    d.st = MS_STOP;
                                    d.nack = tx_cur & q.rack;
                                    d.sda_low = 1'b1;
                                end else begin
                                    d.seq = nseq;
                                    d.bit_cnt = 4'h0;
                                    d.sh = nb;
                                    d.sda_low = ntx & ~nb[7];
                                end
                            end else begin
                                d.bit_cnt = q.bit_cnt + 4'h1;
                                if (q.bit_cnt == 4'h7) begin
                                    d.sda_low = ~tx_cur & (q.seq != last);
                                end else begin
                                    d.sda_low = tx_cur & ~q.sh[7];
                                end
                            end
                        end
                    endcase
                end
            end
            MS_STOP: begin
                if (tick) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.scl_low = 1'b0;
                        2'h1: d.sda_low = 1'b0;
                        2'h2: d.sda_low = 1'b0;
                        default: d.st = MS_IDLE;
                    endcase
                end
            end
            default: d.st = MS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= MST_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe_n = ~q.scl_low;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = ~q.sda_low;
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

endmodule : tsi_mst

/* tsi_bus_properties.sv */
`timescale 1ns/10ps
module tsi_bus_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bus signals
    input wire logic m_scl_o,
    input wire logic m_scl_oe_n,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic [10:0] low_q;
    logic [10:0] low_d;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Longest device drive is an ack plus one zero byte, plus slack
    always_comb low_d = d_sda_oe_n ? 11'h000 : low_q + 11'h001;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            low_q <= 11'h000;
        else
            low_q <= low_d;
    end

    a_dev_pull_only: assert property (!d_sda_o)
        else $error("device drives sda high");
    a_scl_by_master: assert property (!scl |-> !m_scl_oe_n)
        else $error("scl low without master");
    // Release in clock high is allowed: START and STOP end a transfer
    a_hold_high: assert property ($past(scl) && scl
        |-> !$fell(d_sda_oe_n))
        else $error("device sda moved while scl high");
    a_ack_spans: assert property ($rose(scl) && !d_sda_oe_n
        |=> (!d_sda_oe_n && !sda)[*8])
        else $error("ack not held through clock high");
    a_stop_release: assert property (scl && $rose(sda)
        |=> d_sda_oe_n[*8])
        else $error("device drives after stop");
    a_start_release: assert property (scl && $fell(sda)
        |=> d_sda_oe_n[*8])
        else $error("device drives after start");
    a_change_low: assert property ($changed(d_sda_oe_n)
        && !(scl && d_sda_oe_n) |-> !scl && !$past(scl, 4))
        else $error("device sda change not in clock low");
    a_low_bounded: assert property (low_q < 11'h3E8)
        else $error("device holds sda too long");

    cover property ($rose(scl) && !d_sda_oe_n);
    cover property (scl && $rose(sda));
    cover property (scl && $fell(sda));
endmodule : tsi_bus_properties

/* test_tsi.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_tsi;
    import tsi_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, reg_we, e;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] regs [4] = '{16'h2580, 16'h1234, 16'hEC00, 16'h0F0F};
    logic [15:0] tv [3] = '{16'h1900, 16'h1000, 16'hEC00};
    logic [15:0] temp_value = 16'h0000;
    logic [15:0] upper_temp_limit = 16'h1900;
    logic [15:0] lower_temp_limit = 16'h0C80;
    logic interrupt_mode_select = 1'b1;
    logic warning_polarity = 1'b0;
    logic warning_condition_flag, alert_o, hs_mode;
    logic hs_seen = 1'b0;
    logic scl_b = 1'b1;
    logic sda_b = 1'b1;
    logic [1:0] strap_a = 2'h1;
    logic strap_b = 1'b1;
    int miscompares = 0;
    int num_checks = 0;
    tsi_bus_if bi();
    tsi_bus_if bi2();

    assign bi2.m_scl_o = 1'b0;
    assign bi2.m_sda_o = 1'b0;
    assign bi2.m_scl_oe_n = scl_b;
    assign bi2.m_sda_oe_n = sda_b;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (reg_we) regs[reg_addr[1:0]] <= reg_wdata;

    tsi_mst i_tsi_mst (.ref_clk, .arst_n, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .bus(bi.mst));
    tsi_dev #(.TIMEOUT_CYC(200)) i_tsi_dev (.ref_clk, .arst_n,
        .bus(bi.dev), .address_strap_a(strap_a), .address_strap_b(strap_b),
        .reg_addr, .reg_rdata(regs[reg_addr[1:0]]), .reg_wdata, .reg_we,
        .temp_value, .upper_temp_limit, .lower_temp_limit,
        .interrupt_mode_select, .warning_polarity,
        .warning_condition_flag, .alert_o, .hs_mode);
    // Second end faces a bench-driven master for the stalled clock case
    tsi_dev #(.TIMEOUT_CYC(200)) i_tsi_dev_b (.ref_clk, .arst_n,
        .bus(bi2.dev), .address_strap_a(strap_a), .address_strap_b(strap_b),
        .reg_addr(), .reg_rdata(16'h0000), .reg_wdata(), .reg_we(),
        .temp_value, .upper_temp_limit, .lower_temp_limit,
        .interrupt_mode_select, .warning_polarity,
        .warning_condition_flag(), .alert_o(), .hs_mode());
    tsi_bus_properties i_tsi_bus_properties (.ref_clk, .arst_n,
        .m_scl_o(bi.m_scl_o), .m_scl_oe_n(bi.m_scl_oe_n),
        .m_sda_o(bi.m_sda_o), .m_sda_oe_n(bi.m_sda_oe_n),
        .d_sda_o(bi.d_sda_o), .d_sda_oe_n(bi.d_sda_oe_n),
        .scl(bi.scl), .sda(bi.sda));

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Answer taken at the very edge that sees pready high
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic xfer(input logic [6:0] ad, input logic [10:0] c);
        apb(1'b1, OFF_ADDR, {25'h0, ad});
        apb(1'b1, OFF_CMD, {21'h0, c});
        // A hung transfer is left to the watchdog
        do begin
            apb(1'b0, OFF_STAT, 32'h0);
            if (hs_mode === 1'b1) hs_seen = 1'b1;
        end while (q[STAT_BUSY_BIT] !== 1'b0);
    endtask : xfer

    task automatic get(input logic [15:0] x);
        apb(1'b0, OFF_RDATA, 32'h0);
        `CHK(q[15:0], x)
    endtask : get

    task automatic bb(input logic d, input logic c);
        sda_b <= d;
        scl_b <= c;
        repeat (25) @(posedge ref_clk);
    endtask : bb

    task final_report;
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial begin
        #2500000;
        miscompares++;
        final_report;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, OFF_ADDR, 32'h0);
        `CHK(q[6:0], ADDR_BASE)
        apb(1'b1, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        xfer(GC_ADDR, 11'h100);
        get(16'h2580);
        apb(1'b1, OFF_WDATA, 32'hA55A);
        xfer(7'h49, 11'h201);
        `CHK(q[STAT_NACK_BIT], 1'b0)
        `CHK(regs[1], 16'hA55A)
        xfer(7'h49, 11'h100);
        get(16'hA55A);
        xfer(7'h49, 11'h100);
        get(16'hA55A);
        xfer(7'h49, 11'h002);
        xfer(7'h49, 11'h100);
        get(16'hEC00);
        xfer(7'h44, 11'h201);
        `CHK(q[STAT_NACK_BIT], 1'b1)
        `CHK(reg_addr, 8'h02)
        apb(1'b1, OFF_WDATA, 32'h5AA5);
        xfer(GC_ADDR, 11'h203);
        `CHK(q[STAT_NACK_BIT], 1'b1)
        `CHK(regs[3], 16'h0F0F)
        `CHK(reg_addr, 8'h02)
        xfer(7'h49, 11'h500);
        `CHK(hs_seen, 1'b1)
        `CHK(hs_mode, 1'b0)
        `CHK(q[STAT_NACK_BIT], 1'b0)
        get(16'hEC00);
        for (int p = 0; p < 2; p++) begin
            warning_polarity <= p[0];
            interrupt_mode_select <= p[0];
            for (int k = 0; k < 3; k++) begin
                temp_value <= tv[k];
                repeat (3) @(posedge ref_clk);
                e = (k < 2) ? p[0] : ~p[0];
                `CHK(warning_condition_flag, e)
                `CHK(alert_o, p[0] ? e : 1'b1)
            end
        end
        // Straps are only taken after a reset
        strap_a <= 2'h2;
        strap_b <= 1'b0;
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        xfer(7'h46, 11'h100);
        `CHK(q[STAT_NACK_BIT], 1'b0)
        get(16'h2580);
        bb(1'b1, 1'b1);
        bb(1'b0, 1'b1);
        bb(1'b0, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            bb(q[0], 1'b0);
            q = {24'h0, 8'h8C} >> i;
            bb(q[0], 1'b0);
            bb(q[0], 1'b1);
            bb(q[0], 1'b0);
        end
        bb(1'b1, 1'b0);
        `CHK(bi2.sda, 1'b0)
        repeat (300) @(posedge ref_clk);
        `CHK(bi2.sda, 1'b1)
        final_report;
    end
endmodule : test_tsi
